// *** design/csf_pkg.sv ***
// Summary of operation
// RULE_01: Full-speed clock needs high-power external or fast crystal mode.
// RULE_02: Divider codes 00 to 11 divide the bus source by one to four.
// RULE_03: Division applies only with clock select 00; else undivided.
// RULE_04: Dual-speed start-up runs code from internal during start-up.
// RULE_05: Without dual-speed, crystal modes hold code for 1024 oscillations.
// RULE_06: When the start-up timer expires, return to the primary source.
// RULE_07: Dual-speed applies after power-on, powerup timer and wake-up.
// RULE_08: Start-up done status is 1 on primary, 0 on internal source.
// RULE_09: Monitor enabled by its config bit, in every external mode.
// RULE_10: Failure monitor stays inactive until the start-up timer expires.
// RULE_11: Monitor sample clock is the slow oscillator divided by 64.
// RULE_12: Detector latch set on external fall, cleared on sample rise.
// RULE_13: Failure when a whole sample half period has no primary low.
// RULE_14: On failure switch to an internal source and set the fail flag.
// RULE_15: Fail flag raises the interrupt only while its enable is set.
// RULE_16: After failure stay internal; never return automatically.
// RULE_17: Fallback internal source follows the internal frequency select.
// RULE_18: Reset or select high bit toggle clears fail-safe; timer restarts.
// RULE_19: Restart runs internal; on timeout clear fail-safe, go external.
// RULE_20: Fail flag may be cleared independently of the fail-safe state.
// RULE_21: Non-crystal modes skip the start-up timer; monitor active at once.
// RULE_22: Enabling the failure monitor also enables dual-speed start-up.
// RULE_23: Start-up timer counts 1024 oscillations; runs after resets, wakes.
// RULE_24: Fail flag stays set until written zero; hardware set wins.
package csf_pkg;

   // ==========================================================
   // Register map, byte addresses on the APB
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_OSC = 8'h04;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h08;
   localparam logic [7:0] ADDR_IRQ_FLAG = 8'h0c;
   localparam logic [7:0] ADDR_DIV = 8'h10;

   // Bit position of the enable and flag in their registers
   localparam int IRQ_BIT = 7;
   // Bit position of the select high bit in oscillator_control
   localparam int SEL_HIGH_BIT = 1;

   // ==========================================================
   // Reset values
   localparam logic [7:0] CFG_RESET = 8'h02;
   localparam logic [7:0] OSC_RESET = 8'h30;
   localparam logic [7:0] DIV_RESET = 8'h00;

   // ==========================================================
   // Primary clock configuration codes
   localparam logic [3:0] MODE_SLOW_XTAL = 4'h0;
   localparam logic [3:0] MODE_XTAL = 4'h1;
   localparam logic [3:0] MODE_FAST_XTAL = 4'h2;
   localparam logic [3:0] MODE_RES_CAP = 4'h3;
   localparam logic [3:0] MODE_EXT_HIGH = 4'h4;
   localparam logic [3:0] MODE_EXT_LOW = 4'h5;
   localparam logic [3:0] MODE_INT = 4'h8;
   localparam logic [3:0] MODE_INT_OUT = 4'h9;

   // ==========================================================
   // Counts
   localparam logic [10:0] SUT_COUNT = 11'h400;
   localparam logic [5:0] SAMPLE_RISE_AT = 6'h1f;
   localparam logic [5:0] SAMPLE_FALL_AT = 6'h3f;
   localparam logic [1:0] SEL_PRIMARY = 2'h0;

   // ==========================================================
   // Register layouts
   typedef struct packed {
      logic dual_speed_startup_enable;
      logic failsafe_monitor_enable;
      logic [1:0] spare;
      logic [3:0] primary_clock_config;
   } csf_cfg_t;

   typedef struct packed {
      logic spare_hi;
      logic [2:0] internal_freq_select;
      logic startup_done_status;
      logic spare_lo;
      logic [1:0] system_clock_select;
   } csf_osc_t;

   typedef struct packed {
      logic [3:0] spare;
      logic usb_full_speed_enable;
      logic bus_clock_prediv_select;
      logic [1:0] core_clock_divider;
   } csf_div_t;

   // Wake and restart events, one-cycle pulses
   typedef struct packed {
      logic brownout_reset;
      logic wake_from_sleep;
      logic powerup_timer_expired;
      logic oscillator_enable;
   } csf_evt_t;

   // Clock control outputs
   typedef struct packed {
      logic exec_hold;
      logic run_internal;
      logic [2:0] internal_source;
      logic sys_tick;
      logic usb_clk_enable;
      logic startup_done;
      logic failsafe_active;
      logic fail_irq;
   } csf_out_t;

   typedef enum logic [1:0] {
      CS_STARTUP,
      CS_PRIMARY,
      CS_FAILED
   } csf_state_t;

endpackage

// *** design/csf_clock_ctrl.sv ***
`timescale 1ns/100ps
module csf_clock_ctrl (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock sources, sampled levels
   input wire logic ext_clk,
   input wire logic slow_osc,
   // Restart events
   input wire csf_pkg::csf_evt_t evt,
   // Clock control outputs
   output csf_pkg::csf_out_t clk_out
);

   // ==========================================================
   // Register file
   csf_pkg::csf_cfg_t cfg, next_cfg;
   csf_pkg::csf_osc_t osc, next_osc;
   csf_pkg::csf_div_t divr, next_divr;
   logic irq_en, next_irq_en;
   logic flag, next_flag;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic do_wr, mapped, sel_toggle, fail_det;
   logic [7:0] rd_byte;

   always_comb begin
      next_cfg = cfg;
      next_osc = osc;
      next_divr = divr;
      next_irq_en = irq_en;
      next_flag = flag;
      do_wr = psel & penable & pready & pwrite;
      mapped = (paddr == csf_pkg::ADDR_CFG) | (paddr == csf_pkg::ADDR_OSC)
         | (paddr == csf_pkg::ADDR_IRQ_EN) | (paddr == csf_pkg::ADDR_IRQ_FLAG)
         | (paddr == csf_pkg::ADDR_DIV);
      sel_toggle = do_wr & (paddr == csf_pkg::ADDR_OSC)
         & (pwdata[csf_pkg::SEL_HIGH_BIT]
            != osc.system_clock_select[csf_pkg::SEL_HIGH_BIT]);
      if (do_wr) begin
         case (paddr)
            csf_pkg::ADDR_CFG: next_cfg = pwdata[7:0];
            csf_pkg::ADDR_OSC: begin
               next_osc.internal_freq_select = pwdata[6:4];
               next_osc.system_clock_select = pwdata[1:0];
            end
            csf_pkg::ADDR_IRQ_EN: next_irq_en = pwdata[csf_pkg::IRQ_BIT];
            csf_pkg::ADDR_IRQ_FLAG: begin
               // Writing zero clears, writing one leaves as is
               if (!pwdata[csf_pkg::IRQ_BIT]) begin
                  next_flag = 1'b0; // see RULE_24 see RULE_20
               end
            end
            csf_pkg::ADDR_DIV: next_divr = pwdata[7:0];
            default: ;
         endcase
      end
      if (fail_det) begin
         next_flag = 1'b1; // see RULE_14 see RULE_24
      end
      case (paddr)
         csf_pkg::ADDR_CFG: rd_byte = cfg;
         csf_pkg::ADDR_OSC: rd_byte = osc;
         csf_pkg::ADDR_IRQ_EN: rd_byte = {irq_en, 7'h00};
         csf_pkg::ADDR_IRQ_FLAG: rd_byte = {flag, 7'h00};
         csf_pkg::ADDR_DIV: rd_byte = divr;
         default: rd_byte = 8'h00;
      endcase
      next_pready = psel & penable & ~pready;
      next_pslverr = psel & penable & ~pready & ~mapped;
      next_prdata = (psel & penable & ~pready & ~pwrite)
         ? {24'h000000, rd_byte} : 32'h00000000;
   end

   // ==========================================================
   // Sampling of the primary and slow internal oscillators
   logic ext_q, next_ext_q, slow_q, next_slow_q;
   logic [5:0] samp_cnt, next_samp_cnt;
   logic latch, next_latch, armed, next_armed;
   logic ext_fall, slow_rise, samp_rise, samp_fall, monitor_on;
   logic external_mode, uses_sut;
   csf_pkg::csf_state_t state, next_state;

   always_comb begin
      ext_fall = ext_q & ~ext_clk;
      slow_rise = ~slow_q & slow_osc;
      next_ext_q = ext_clk;
      next_slow_q = slow_osc;
      // Sample clock is the top bit of a divide-by-64 counter
      next_samp_cnt = slow_rise ? samp_cnt + 6'h01 : samp_cnt; // see RULE_11
      samp_rise = slow_rise & (samp_cnt == csf_pkg::SAMPLE_RISE_AT);
      samp_fall = slow_rise & (samp_cnt == csf_pkg::SAMPLE_FALL_AT);
      external_mode = (cfg.primary_clock_config != csf_pkg::MODE_INT)
         & (cfg.primary_clock_config != csf_pkg::MODE_INT_OUT);
      uses_sut = (cfg.primary_clock_config == csf_pkg::MODE_SLOW_XTAL)
         | (cfg.primary_clock_config == csf_pkg::MODE_XTAL) // see RULE_21
         | (cfg.primary_clock_config == csf_pkg::MODE_FAST_XTAL);
      monitor_on = cfg.failsafe_monitor_enable & external_mode // see RULE_09
         & (state == csf_pkg::CS_PRIMARY); // see RULE_10
      // Set wins over clear when both edges meet
      next_latch = latch;
      if (samp_rise) begin
         next_latch = 1'b0; // see RULE_12
      end
      if (ext_fall) begin
         next_latch = 1'b1; // see RULE_12
      end
      // Armed only after a full rising edge, so a half period is whole
      next_armed = armed;
      if (!monitor_on) begin
         next_armed = 1'b0;
      end else if (samp_rise) begin
         next_armed = 1'b1;
      end
      fail_det = monitor_on & armed & samp_fall
         & ~latch & ~ext_fall; // see RULE_13
   end

   // ==========================================================
   // Start-up timer and source state machine
   logic [10:0] sut_cnt, next_sut_cnt;
   logic fs_cond, next_fs_cond;
   logic restart, sut_done;

   always_comb begin
      next_state = state;
      next_sut_cnt = sut_cnt;
      next_fs_cond = fs_cond;
      sut_done = (sut_cnt == csf_pkg::SUT_COUNT);
      restart = evt.brownout_reset | evt.wake_from_sleep
         | evt.powerup_timer_expired | evt.oscillator_enable // see RULE_23
         | (sel_toggle & fs_cond); // see RULE_18
      case (state)
         csf_pkg::CS_STARTUP: begin
            if (ext_fall && !sut_done) begin
               next_sut_cnt = sut_cnt + 11'h001; // see RULE_23
            end
            if (!uses_sut || sut_done) begin
               next_state = csf_pkg::CS_PRIMARY; // see RULE_06
               next_fs_cond = 1'b0; // see RULE_19
               next_sut_cnt = 11'h000;
            end
         end
         csf_pkg::CS_PRIMARY: begin
            if (fail_det) begin
               next_state = csf_pkg::CS_FAILED; // see RULE_14
               next_fs_cond = 1'b1;
            end
         end
         csf_pkg::CS_FAILED: begin
            next_state = csf_pkg::CS_FAILED; // see RULE_16
         end
         default: next_state = csf_pkg::CS_STARTUP;
      endcase
      if (restart) begin
         next_state = csf_pkg::CS_STARTUP; // see RULE_07 see RULE_18
         next_sut_cnt = 11'h000;
      end
      if (evt.brownout_reset) begin
         next_fs_cond = 1'b0; // see RULE_18
      end
   end

   // ==========================================================
   // Output stage
   logic dual, irq_want, on_primary;
   logic [1:0] div_cnt, next_div_cnt;
   csf_pkg::csf_out_t next_out;

   always_comb begin
      dual = cfg.dual_speed_startup_enable
         | cfg.failsafe_monitor_enable; // see RULE_22
      irq_want = flag & irq_en;
      on_primary = (state == csf_pkg::CS_PRIMARY);
      next_out.run_internal = (state == csf_pkg::CS_FAILED) // see RULE_14
         | ((state == csf_pkg::CS_STARTUP) & uses_sut
            & (dual | fs_cond)); // see RULE_04 see RULE_19
      next_out.exec_hold = (state == csf_pkg::CS_STARTUP) & uses_sut
         & ~dual & ~fs_cond; // see RULE_05
      next_out.internal_source = osc.internal_freq_select; // see RULE_17
      next_out.startup_done = on_primary; // see RULE_08
      next_out.failsafe_active = fs_cond;
      next_out.fail_irq = irq_want; // see RULE_15
      next_out.usb_clk_enable = on_primary // see RULE_01
         & divr.usb_full_speed_enable
         & ((cfg.primary_clock_config == csf_pkg::MODE_EXT_HIGH)
            | (cfg.primary_clock_config == csf_pkg::MODE_FAST_XTAL));
      // Divider only while the primary source drives with select 00
      if ((osc.system_clock_select == csf_pkg::SEL_PRIMARY)
            && on_primary) begin // see RULE_03
         next_out.sys_tick = (div_cnt == divr.core_clock_divider);
         next_div_cnt = next_out.sys_tick
            ? 2'h0 : div_cnt + 2'h1; // see RULE_02
      end else begin
         next_out.sys_tick = 1'b1;
         next_div_cnt = 2'h0;
      end
   end

   // ==========================================================
   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= csf_pkg::CFG_RESET;
         osc <= csf_pkg::OSC_RESET;
         divr <= csf_pkg::DIV_RESET;
         irq_en <= 1'b0;
         flag <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         ext_q <= 1'b0;
         // High, so an oscillator already high gives no false rise
         slow_q <= 1'b1;
         samp_cnt <= 6'h00;
         latch <= 1'b0;
         armed <= 1'b0;
         state <= csf_pkg::CS_STARTUP;
         sut_cnt <= 11'h000;
         fs_cond <= 1'b0;
         div_cnt <= 2'h0;
         clk_out <= '0;
      end else begin
         cfg <= next_cfg;
         osc <= {next_osc[7:4], on_primary, next_osc[2:0]};
         divr <= next_divr;
         irq_en <= next_irq_en;
         flag <= next_flag;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         ext_q <= next_ext_q;
         slow_q <= next_slow_q;
         samp_cnt <= next_samp_cnt;
         latch <= next_latch;
         armed <= next_armed;
         state <= next_state;
         sut_cnt <= next_sut_cnt;
         fs_cond <= next_fs_cond;
         div_cnt <= next_div_cnt;
         clk_out <= next_out;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_fail_sets_flag: assert property ( // see RULE_14
      fail_det |=> flag && state == csf_pkg::CS_FAILED)
      else $error("clock failure did not set flag and fail state");

   a_flag_sticky: assert property ( // see RULE_24
      flag && !(do_wr && paddr == csf_pkg::ADDR_IRQ_FLAG) |=> flag)
      else $error("clock fail flag dropped without a clear");

   a_irq_gate: assert property ( // see RULE_15
      ##1 (clk_out.fail_irq == $past(irq_want)))
      else $error("interrupt output does not follow flag and enable");

   a_no_auto_return: assert property ( // see RULE_16
      state == csf_pkg::CS_FAILED && !restart
      |=> state == csf_pkg::CS_FAILED)
      else $error("left failed state without restart");

   a_startup_length: assert property ( // see RULE_23
      state == csf_pkg::CS_STARTUP && uses_sut && !sut_done
      |=> state != csf_pkg::CS_PRIMARY)
      else $error("primary selected before 1024 oscillations");

   a_switch_back: assert property ( // see RULE_06
      state == csf_pkg::CS_STARTUP && sut_done && !restart
      |=> state == csf_pkg::CS_PRIMARY ##1 clk_out.startup_done)
      else $error("no switch to primary after start-up timer");

   a_hold_single: assert property ( // see RULE_05
      state == csf_pkg::CS_STARTUP && uses_sut && !dual && !fs_cond
      |=> clk_out.exec_hold && !clk_out.run_internal)
      else $error("execution not held during start-up");

   a_dual_speed: assert property ( // see RULE_04
      state == csf_pkg::CS_STARTUP && uses_sut && dual
      |=> clk_out.run_internal && !clk_out.exec_hold)
      else $error("dual-speed start-up not running internal");

   a_done_status: assert property ( // see RULE_08
      ##1 (clk_out.startup_done == $past(on_primary)))
      else $error("start-up done status wrong");

   a_monitor_idle: assert property ( // see RULE_10
      state != csf_pkg::CS_PRIMARY |-> !fail_det)
      else $error("failure detected during start-up");

   a_latch_clear: assert property ( // see RULE_12
      samp_rise && !ext_fall |=> !latch)
      else $error("detector latch not cleared by sample edge");

endmodule

// *** test/csf_osc_model.sv ***
`timescale 1ns/100ps
module csf_osc_model #(
   parameter int EXT_HALF = 2,
   parameter int SLOW_HALF = 2
) (
   // Clock and enable
   input wire logic pclk,
   input wire logic ext_run,
   // Oscillator levels
   output logic ext_clk,
   output logic slow_osc
);
   int ext_cnt = 0;
   int slow_cnt = 0;
   initial begin
      ext_clk = 1'b0;
      slow_osc = 1'b0;
   end
   // Crystal toggles only while running; a dead crystal stalls at its level
   always @(posedge pclk) begin
      if (ext_run) begin
         ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
         if (ext_cnt == EXT_HALF - 1) begin
            ext_clk <= ~ext_clk;
         end
      end
   end
   // Slow internal oscillator runs free
   always @(posedge pclk) begin
      slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
      if (slow_cnt == SLOW_HALF - 1) begin
         slow_osc <= ~slow_osc;
      end
   end
endmodule

// *** test/test_clock_startup_failsafe_ctrl.sv ***
`timescale 1ns/100ps
module test_clock_startup_failsafe_ctrl;
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] exp;
      logic err;
   } csf_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ext_clk;
   logic slow_osc;
   logic ext_run = 1'b0;
   csf_pkg::csf_evt_t evt = '0;
   csf_pkg::csf_out_t clk_out;
   int err_total = 0;
   int checks = 0;
   csf_row_t rows [8];
   logic [31:0] rd;
   logic er;
   int k;

   always #5 pclk = ~pclk;

   csf_clock_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_clk(ext_clk), .slow_osc(slow_osc), .evt(evt), .clk_out(clk_out));

   csf_osc_model osc_u (.pclk(pclk), .ext_run(ext_run), .ext_clk(ext_clk),
      .slow_osc(slow_osc));

   // ==========================================
   // Checking and bus tasks
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a transfer that never gets an answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0);
      check("register read", rd, {24'h0, exp});
   endtask

   // Waits for one output bit under a bound
   task automatic wait_bit(input int idx, input logic want, input int lim);
      int n;
      n = 0;
      while (clk_out[idx] !== want && n < lim) begin
         @(posedge pclk);
         n++;
      end
      check("wait output bit", {31'h0, clk_out[idx]}, {31'h0, want});
   endtask

   task automatic pulse_evt(input csf_pkg::csf_evt_t e);
      @(posedge pclk);
      evt <= e;
      @(posedge pclk);
      evt <= '0;
   endtask

   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #600_000;
      err_total++;
      conclude();
   end

   // ==========================================
   // Main sequence
   initial begin
      rows[0] = '{1'b0, csf_pkg::ADDR_CFG, 32'h0, 32'h02, 1'b0};
      rows[1] = '{1'b0, csf_pkg::ADDR_OSC, 32'h0, 32'h30, 1'b0};
      rows[2] = '{1'b0, csf_pkg::ADDR_IRQ_EN, 32'h0, 32'h0, 1'b0};
      rows[3] = '{1'b0, csf_pkg::ADDR_IRQ_FLAG, 32'h0, 32'h0, 1'b0};
      rows[4] = '{1'b0, csf_pkg::ADDR_DIV, 32'h0, 32'h0, 1'b0};
      rows[5] = '{1'b1, csf_pkg::ADDR_IRQ_FLAG, 32'h80, 32'h0, 1'b0};
      rows[6] = '{1'b1, csf_pkg::ADDR_DIV, 32'hffffff0f, 32'h0f, 1'b0};
      rows[7] = '{1'b1, 8'h14, 32'hffffffff, 32'h0, 1'b1};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      check("exec_hold", clk_out.exec_hold, 1'b1);
      check("startup_done", clk_out.startup_done, 1'b0);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            apb(1'b1, rows[i].a, rows[i].d);
         end
         apb(1'b0, rows[i].a, 32'h0);
         check("row data", rd, rows[i].exp);
         check("row error", {31'h0, er}, {31'h0, rows[i].err});
      end
      // Crystal start-up count
      ext_run <= 1'b1;
      repeat (3900) @(posedge pclk);
      check("early done", clk_out.startup_done, 1'b0);
      wait_bit(2, 1'b1, 1000);
      check("hold off", clk_out.exec_hold, 1'b0);
      rd_chk(csf_pkg::ADDR_OSC, 8'h38);
      // Core divider codes
      for (int d = 0; d < 4; d++) begin
         wr(csf_pkg::ADDR_DIV, 8'h08 | d[7:0]);
         // Let the divider settle from the previous setting
         repeat (4) @(posedge pclk);
         k = 0;
         repeat (24) @(posedge pclk) k += (clk_out.sys_tick === 1'b1);
         check("ticks", k, 24 / (d + 1));
         check("usb on", clk_out.usb_clk_enable, 1'b1);
      end
      wr(csf_pkg::ADDR_OSC, 8'h31);
      repeat (4) @(posedge pclk);
      k = 0;
      repeat (24) @(posedge pclk) k += (clk_out.sys_tick === 1'b1);
      check("ticks undivided", k, 24);
      wr(csf_pkg::ADDR_DIV, 8'h03);
      repeat (2) @(posedge pclk);
      check("usb off", clk_out.usb_clk_enable, 1'b0);
      // Failure and recovery
      wr(csf_pkg::ADDR_CFG, 8'h42);
      wr(csf_pkg::ADDR_IRQ_EN, 8'h80);
      wr(csf_pkg::ADDR_OSC, 8'h50);
      ext_run <= 1'b0;
      wait_bit(1, 1'b1, 1000);
      repeat (2) @(posedge pclk);
      check("internal", clk_out.run_internal, 1'b1);
      check("source", clk_out.internal_source, 3'h5);
      check("irq", clk_out.fail_irq, 1'b1);
      rd_chk(csf_pkg::ADDR_IRQ_FLAG, 8'h80);
      wr(csf_pkg::ADDR_IRQ_EN, 8'h00);
      repeat (3) @(posedge pclk);
      check("irq masked", clk_out.fail_irq, 1'b0);
      wr(csf_pkg::ADDR_IRQ_FLAG, 8'h00);
      rd_chk(csf_pkg::ADDR_IRQ_FLAG, 8'h00);
      check("still failed", clk_out.failsafe_active, 1'b1);
      ext_run <= 1'b1;
      repeat (500) @(posedge pclk);
      check("no auto return", clk_out.run_internal, 1'b1);
      wr(csf_pkg::ADDR_OSC, 8'h52);
      wr(csf_pkg::ADDR_OSC, 8'h50);
      check("restart internal", clk_out.run_internal, 1'b1);
      wait_bit(2, 1'b1, 5000);
      check("cleared", clk_out.failsafe_active, 1'b0);
      check("external", clk_out.run_internal, 1'b0);
      // Wake with a dead crystal: monitor idle, code runs internal
      ext_run <= 1'b0;
      pulse_evt(4'b0100);
      repeat (1000) @(posedge pclk);
      check("monitor idle", clk_out.failsafe_active, 1'b0);
      check("dual forced", clk_out.run_internal, 1'b1);
      check("running", clk_out.exec_hold, 1'b0);
      ext_run <= 1'b1;
      wait_bit(2, 1'b1, 5000);
      // Brown-out and reset clear the fail-safe condition
      ext_run <= 1'b0;
      wait_bit(1, 1'b1, 1000);
      pulse_evt(4'b1000);
      repeat (3) @(posedge pclk);
      check("bor clear", clk_out.failsafe_active, 1'b0);
      // Monitor is idle during start-up, so restart the crystal first
      ext_run <= 1'b1;
      wait_bit(2, 1'b1, 5000);
      ext_run <= 1'b0;
      wait_bit(1, 1'b1, 6000);
      do_reset();
      check("reset clear", clk_out.failsafe_active, 1'b0);
      rd_chk(csf_pkg::ADDR_IRQ_FLAG, 8'h00);
      // External clock mode skips the start-up timer
      wr(csf_pkg::ADDR_CFG, 8'h44);
      pulse_evt(4'b0100);
      wait_bit(2, 1'b1, 20);
      wait_bit(1, 1'b1, 1000);
      conclude();
   end
endmodule
